// File: iopfs_top.sv
// I/O pin function select: registers on Wishbone and the pin multiplexer
//
// What this block does
// - LVDS transmit off leaves LVDS high-Z; GPIO select and clock output enables govern pin 5/6 CMOS buffers.
// - LVDS transmit on disables the CMOS output buffers on pins 5 and 6.
// - Seven-bit GPIO select, bit n for pin n, 1 means GPIO, resets 0x66.
// - A set GPIO select bit overrides every other output function of that pin, except the LVDS transmit disable on pins 5 and 6.
// - Pin 6 clock output: transceiver clock two at 0, clock unit clock at 1.
// - Pin 5 clock output: transceiver clock one at 0, clock unit clock at 1.
// - External clock is taken from pin 6 at 0 and pin 5 at 1.
// - Pin 6 clock output drives only when its enable bit is 1; resets 0.
// - Pin 5 clock output drives only when its enable bit is 1; resets 0.
// - Pin 3 serial select acts only while pin 3 GPIO bit is 0.
// - Pin 3: sync output always driven at 0, serial data line two at 1.
// - Pin 1 (serial select, trim/SPI bit 0): sync output at 0, second slave select at 1; resets 1.
// - Start-sync input comes from pin 1 at 0 and pin 3 at 1.
// - Five-bit signed oscillator trim is held and passed out; 0 is nominal.
// - Reserved bits of clock select and output enable read zero, are written zero.
// - LVDS current and bias trim codes go unchanged to the driver; 00 is zero current.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
module iopfs_top (
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [iopfs_pkg::ADR_W-1:0] I_WB_ADR,
   input wire logic [iopfs_pkg::DAT_W-1:0] I_WB_DAT,
   input wire logic [3:0] I_WB_SEL,
   output logic [iopfs_pkg::DAT_W-1:0] O_WB_DAT,
   output logic O_WB_ACK,
   input wire logic [iopfs_pkg::PIN_N-1:0] I_IO_IN,
   output logic [iopfs_pkg::PIN_N-1:0] O_IO_OUT,
   output logic [iopfs_pkg::PIN_N-1:0] O_IO_OE,
   input wire logic [iopfs_pkg::PIN_N-1:0] I_GPIO_OUT,
   input wire logic [iopfs_pkg::PIN_N-1:0] I_GPIO_OE,
   output logic [iopfs_pkg::PIN_N-1:0] O_GPIO_IN,
   input wire logic [2:0] I_ALT_OUT,
   input wire logic [2:0] I_ALT_OE,
   input wire logic I_TRX_CLKOUT_1,
   input wire logic I_TRX_CLKOUT_2,
   input wire logic I_CMU_CLKOUT,
   input wire logic I_TRX_SYNC_OUT,
   input wire logic I_SERIAL_DATA_LINE_TWO_OUT,
   input wire logic I_SERIAL_DATA_LINE_TWO_OE,
   output logic O_SERIAL_DATA_LINE_TWO_IN,
   input wire logic I_SECOND_SLAVE_SELECT_OUTPUT,
   output logic O_TRX_START_SYNC_IN,
   output logic O_EXTCLK,
   output logic O_LVDS_TX_EN,
   output logic [1:0] O_LVDS_DRIVE_CURRENT,
   output logic [1:0] O_LVDS_BIAS_TRIM,
   output logic [4:0] O_OSC_TRIM
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic reg_hit(input logic [iopfs_pkg::ADR_W-1:0] adr,
                                    input logic [7:0] idx);
      reg_hit = (adr[iopfs_pkg::ADR_W-1:2] == idx);
   endfunction

   function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                               input logic [7:0] new_val,
                                               input logic [7:0] mask);
      masked_write = (new_val & mask) | (old_val & ~mask);
   endfunction

   iopfs_pkg::iopfs_state_t st_q;
   iopfs_pkg::iopfs_state_t st_d;

   logic bus_req;
   logic wr_now;
   logic lvds_on;
   logic [6:0] gsel;

   assign bus_req = I_WB_CYC & I_WB_STB;
   // Write lands on the edge where the master samples ack high
   assign wr_now = bus_req & I_WB_WE & st_q.ack & I_WB_SEL[0];
   assign lvds_on = st_q.lvds_gpio[iopfs_pkg::POS_LVDS_TX_EN];
   assign gsel = st_q.lvds_gpio[6:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_d = st_q;
      // Pin inputs cross through two flops
      st_d.pin_meta = I_IO_IN;
      st_d.pin_sync = st_q.pin_meta;

      // Bus slave: one wait state, ack for one cycle
      st_d.ack = bus_req & ~st_q.ack;
      if (bus_req & ~st_q.ack) begin
         if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_LVDS_GPIO)) begin
            st_d.rdat = st_q.lvds_gpio;
         end else if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_SEL)) begin
            st_d.rdat = st_q.clk_sel;
         end else if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_TRIM_SPI)) begin
            st_d.rdat = st_q.trim_spi;
         end else if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_OE)) begin
            st_d.rdat = st_q.clk_oe;
         end else begin
            st_d.rdat = 8'h00;
         end
      end

      if (wr_now) begin
         if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_LVDS_GPIO)) begin
            st_d.lvds_gpio = masked_write(st_q.lvds_gpio, I_WB_DAT[7:0],
                                          iopfs_pkg::WMASK_LVDS_GPIO);
         end
         if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_SEL)) begin
            st_d.clk_sel = masked_write(st_q.clk_sel, I_WB_DAT[7:0],
                                        iopfs_pkg::WMASK_CLK_SEL);
         end
         if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_TRIM_SPI)) begin
            st_d.trim_spi = masked_write(st_q.trim_spi, I_WB_DAT[7:0],
                                         iopfs_pkg::WMASK_TRIM_SPI);
         end
         if (reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_OE)) begin
            st_d.clk_oe = masked_write(st_q.clk_oe, I_WB_DAT[7:0],
                                       iopfs_pkg::WMASK_CLK_OE);
         end
      end

      // Other functions of each pin
      st_d.io_out[0] = I_ALT_OUT[0];
      st_d.io_oe[0] = I_ALT_OE[0];
      st_d.io_out[1] = st_q.trim_spi[iopfs_pkg::POS_PIN1_SERIAL_SELECT] ?
                       I_SECOND_SLAVE_SELECT_OUTPUT : I_TRX_SYNC_OUT;
      st_d.io_oe[1] = 1'b1;
      st_d.io_out[2] = I_ALT_OUT[1];
      st_d.io_oe[2] = I_ALT_OE[1];
      if (st_q.trim_spi[iopfs_pkg::POS_PIN3_SERIAL_SELECT]) begin
         st_d.io_out[3] = I_SERIAL_DATA_LINE_TWO_OUT;
         st_d.io_oe[3] = I_SERIAL_DATA_LINE_TWO_OE;
      end else begin
         st_d.io_out[3] = I_TRX_SYNC_OUT;
         st_d.io_oe[3] = 1'b1;
      end
      st_d.io_out[4] = I_ALT_OUT[2];
      st_d.io_oe[4] = I_ALT_OE[2];
      st_d.io_out[5] = st_q.clk_sel[iopfs_pkg::POS_PIN5_CLOCK_OUT_SELECT] ?
                       I_CMU_CLKOUT : I_TRX_CLKOUT_1;
      st_d.io_oe[5] = st_q.clk_oe[iopfs_pkg::POS_PIN5_CLOCK_OUT_DRIVE_ENABLE];
      st_d.io_out[6] = st_q.clk_sel[iopfs_pkg::POS_PIN6_CLOCK_OUT_SELECT] ?
                       I_CMU_CLKOUT : I_TRX_CLKOUT_2;
      st_d.io_oe[6] = st_q.clk_oe[iopfs_pkg::POS_PIN6_CLOCK_OUT_DRIVE_ENABLE];

      for (int i = 0; i < iopfs_pkg::PIN_N; i++) begin
         if (gsel[i]) begin
            st_d.io_out[i] = I_GPIO_OUT[i];
            st_d.io_oe[i] = I_GPIO_OE[i];
         end
      end
      if (lvds_on) begin
         st_d.io_oe[5] = 1'b0;
         st_d.io_oe[6] = 1'b0;
      end

      // Inputs toward the core
      st_d.gpio_in = st_q.pin_sync;
      st_d.sd2_in = st_q.pin_sync[3];
      st_d.start_sync = st_q.trim_spi[iopfs_pkg::POS_SYNC_SRC_SEL] ?
                        st_q.pin_sync[3] : st_q.pin_sync[1];
      st_d.extclk = st_q.clk_sel[iopfs_pkg::POS_EXTCLK_SEL] ?
                    st_q.pin_sync[5] : st_q.pin_sync[6];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_q <= '0;
         st_q.lvds_gpio <= iopfs_pkg::RST_LVDS_GPIO;
         st_q.clk_sel <= iopfs_pkg::RST_CLK_SEL;
         st_q.trim_spi <= iopfs_pkg::RST_TRIM_SPI;
         st_q.clk_oe <= iopfs_pkg::RST_CLK_OE;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign O_WB_DAT = {24'h000000, st_q.rdat};
   assign O_WB_ACK = st_q.ack;
   assign O_IO_OUT = st_q.io_out;
   assign O_IO_OE = st_q.io_oe;
   assign O_GPIO_IN = st_q.gpio_in;
   assign O_SERIAL_DATA_LINE_TWO_IN = st_q.sd2_in;
   assign O_TRX_START_SYNC_IN = st_q.start_sync;
   assign O_EXTCLK = st_q.extclk;
   assign O_LVDS_TX_EN = lvds_on;
   assign O_LVDS_DRIVE_CURRENT = st_q.clk_sel[iopfs_pkg::POS_LVDS_CUR_HI:
                                             iopfs_pkg::POS_LVDS_CUR_LO];
   assign O_LVDS_BIAS_TRIM = st_q.clk_sel[iopfs_pkg::POS_LVDS_BIAS_HI:0];
   assign O_OSC_TRIM = st_q.trim_spi[iopfs_pkg::POS_OSC_TRIM_HI:iopfs_pkg::POS_OSC_TRIM_LO];

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence s_wr_clk_sel;
      bus_req && I_WB_WE && O_WB_ACK && I_WB_SEL[0] &&
      reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_SEL);
   endsequence

   sequence s_rd_clk_sel;
      bus_req && !I_WB_WE && !O_WB_ACK && reg_hit(I_WB_ADR, iopfs_pkg::IDX_CLK_SEL);
   endsequence

   a_lvds_cmos_off: assert property (lvds_on |=> !O_IO_OE[5] && !O_IO_OE[6])
      else $error("CMOS buffer on pin 5 or 6 driven while LVDS enabled");
   a_lvds_gpio_gov: assert property (!lvds_on && gsel[5] |=> O_IO_OE[5] == $past(I_GPIO_OE[5]))
      else $error("Pin 5 enable not governed by GPIO with LVDS off");
   a_gpio_pin3_wins: assert property (gsel[3] |=> O_IO_OUT[3] == $past(I_GPIO_OUT[3]))
      else $error("Pin 3 not under GPIO control while selected");
   a_pin3_sync_drive: assert property (!gsel[3] && !st_q.trim_spi[2] |=> O_IO_OE[3])
      else $error("Pin 3 sync output not driven");
   a_pin1_slave_sel: assert property (!gsel[1] && st_q.trim_spi[0]
      |=> O_IO_OUT[1] == $past(I_SECOND_SLAVE_SELECT_OUTPUT) && O_IO_OE[1])
      else $error("Pin 1 does not carry the second slave select");
   a_pin6_clk_gate: assert property (!gsel[6] && !lvds_on
      |=> O_IO_OE[6] == $past(st_q.clk_oe[1]))
      else $error("Pin 6 clock drive enable mismatch");
   a_pin5_clk_sel: assert property (!gsel[5] && st_q.clk_sel[5]
      |=> O_IO_OUT[5] == $past(I_CMU_CLKOUT))
      else $error("Pin 5 not carrying the clock unit clock");
   a_sync_src_sel: assert property (st_q.trim_spi[1] |=> O_TRX_START_SYNC_IN == $past(st_q.pin_sync[3]))
      else $error("Start sync not taken from pin 3");
   a_ext_src_sel: assert property (!st_q.clk_sel[4] |=> O_EXTCLK == $past(st_q.pin_sync[6]))
      else $error("External clock not taken from pin 6");
   a_wr_then_rd: assert property (s_wr_clk_sel ##1 !bus_req ##1 s_rd_clk_sel
      |-> ##1 O_WB_DAT[6:0] == $past(I_WB_DAT[6:0], 3) && !O_WB_DAT[7])
      else $error("Clock select readback wrong or reserved bit set");
   a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("Ack held longer than one cycle");
   a_trim_pass: assert property (O_OSC_TRIM == st_q.trim_spi[7:3] && O_LVDS_DRIVE_CURRENT == st_q.clk_sel[3:2])
      else $error("Trim codes not forwarded");

   ////////////////////////////////////////////////////////////////////////////////
   // Pin routing and register bus checks

   sequence s_wr_hit(logic [7:0] idx);
      bus_req && I_WB_WE && O_WB_ACK && I_WB_SEL[0] && reg_hit(I_WB_ADR, idx);
   endsequence

   a_pin6_cmu_sel: assert property (
      !gsel[6] && st_q.clk_sel[6] |=> O_IO_OUT[6] == $past(I_CMU_CLKOUT))
      else $error("Pin 6 not carrying the clock unit clock");

   a_pin6_trx_sel: assert property (
      !gsel[6] && !st_q.clk_sel[6] |=> O_IO_OUT[6] == $past(I_TRX_CLKOUT_2))
      else $error("Pin 6 not carrying transceiver clock two");

   a_pin5_trx_sel: assert property (
      !gsel[5] && !st_q.clk_sel[5] |=> O_IO_OUT[5] == $past(I_TRX_CLKOUT_1))
      else $error("Pin 5 not carrying transceiver clock one");

   a_pin5_clk_gate: assert property (
      !gsel[5] && !lvds_on |=> O_IO_OE[5] == $past(st_q.clk_oe[0]))
      else $error("Pin 5 clock drive enable mismatch");

   a_ext_pin5_src: assert property (
      st_q.clk_sel[4] |=> O_EXTCLK == $past(st_q.pin_sync[5]))
      else $error("External clock not taken from pin 5");

   a_sync_pin1_src: assert property (
      !st_q.trim_spi[1] |=> O_TRX_START_SYNC_IN == $past(st_q.pin_sync[1]))
      else $error("Start sync not taken from pin 1");

   a_pin3_serial: assert property (
      !gsel[3] && st_q.trim_spi[2] |=> O_IO_OUT[3] == $past(I_SERIAL_DATA_LINE_TWO_OUT) &&
      O_IO_OE[3] == $past(I_SERIAL_DATA_LINE_TWO_OE))
      else $error("Pin 3 not carrying serial data line two");

   a_pin3_sync_val: assert property (
      !gsel[3] && !st_q.trim_spi[2] |=> O_IO_OUT[3] == $past(I_TRX_SYNC_OUT))
      else $error("Pin 3 not carrying the sync output");

   a_pin1_sync_out: assert property (
      !gsel[1] && !st_q.trim_spi[0] |=> O_IO_OUT[1] == $past(I_TRX_SYNC_OUT) && O_IO_OE[1])
      else $error("Pin 1 sync output not driven");

   a_gpio_pin0_wins: assert property (
      gsel[0] |=> O_IO_OUT[0] == $past(I_GPIO_OUT[0]) && O_IO_OE[0] == $past(I_GPIO_OE[0]))
      else $error("Pin 0 not under GPIO control while selected");

   a_gpio_gates_serial: assert property (
      gsel[3] && st_q.trim_spi[2] |=> O_IO_OE[3] == $past(I_GPIO_OE[3]))
      else $error("Pin 3 serial select acted while GPIO selected");

   a_lvds_gpio_pin6: assert property (
      !lvds_on && gsel[6] |=> O_IO_OE[6] == $past(I_GPIO_OE[6]))
      else $error("Pin 6 enable not governed by GPIO with LVDS off");

   a_reserved_zero: assert property (
      !st_q.clk_sel[7] && st_q.clk_oe[7:2] == 6'h00)
      else $error("Reserved bit stored");

   a_ack_wait: assert property (
      bus_req && !O_WB_ACK |=> O_WB_ACK)
      else $error("Ack missing after one wait state");

   a_ack_needs_req: assert property (
      !bus_req |=> !O_WB_ACK)
      else $error("Ack without a request");

   a_clk_sel_lands: assert property (
      s_wr_hit(iopfs_pkg::IDX_CLK_SEL) |=>
      st_q.clk_sel == ($past(I_WB_DAT[7:0]) & iopfs_pkg::WMASK_CLK_SEL))
      else $error("Clock select write not stored");

   a_rd_unmapped: assert property (
      bus_req && !I_WB_WE && !O_WB_ACK && reg_hit(I_WB_ADR, 8'h50) |=> O_WB_DAT == 32'h0)
      else $error("Unmapped read not zero");

   a_sel_gate: assert property (
      bus_req && I_WB_WE && O_WB_ACK && !I_WB_SEL[0] |=>
      $stable(st_q.trim_spi) && $stable(st_q.lvds_gpio))
      else $error("Write stored without lane zero selected");

   a_trim_write: assert property (
      s_wr_hit(iopfs_pkg::IDX_TRIM_SPI) |=> O_OSC_TRIM == $past(I_WB_DAT[7:3]))
      else $error("Oscillator trim not taken from write");

   a_lvds_en_write: assert property (
      s_wr_hit(iopfs_pkg::IDX_LVDS_GPIO) |=> O_LVDS_TX_EN == $past(I_WB_DAT[7]))
      else $error("LVDS enable not taken from write");

   a_oe_write: assert property (
      s_wr_hit(iopfs_pkg::IDX_CLK_OE) |=>
      st_q.clk_oe == ($past(I_WB_DAT[7:0]) & iopfs_pkg::WMASK_CLK_OE))
      else $error("Clock output enable write wrong");

   a_codes_write: assert property (
      s_wr_hit(iopfs_pkg::IDX_CLK_SEL) |=> O_LVDS_BIAS_TRIM == $past(I_WB_DAT[1:0]) &&
      O_LVDS_DRIVE_CURRENT == $past(I_WB_DAT[3:2]))
      else $error("LVDS codes not taken from write");

endmodule // iopfs_top
`default_nettype wire

// File: iopfs_pkg.sv
// Constants for the I/O pin function select block
`default_nettype none
package iopfs_pkg;
   // Wishbone geometry
   localparam int ADR_W = 10;
   localparam int DAT_W = 32;
   localparam int REG_W = 8;
   localparam int PIN_N = 7;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_LVDS_GPIO = 8'h4d;
   localparam logic [7:0] IDX_CLK_SEL = 8'h4e;
   localparam logic [7:0] IDX_TRIM_SPI = 8'h4f;
   localparam logic [7:0] IDX_CLK_OE = 8'h51;
   // Values after reset
   localparam logic [7:0] RST_LVDS_GPIO = 8'h66;
   localparam logic [7:0] RST_CLK_SEL = 8'h00;
   localparam logic [7:0] RST_TRIM_SPI = 8'h05;
   localparam logic [7:0] RST_CLK_OE = 8'h00;
   // Writable bits; reserved bits are never stored
   localparam logic [7:0] WMASK_LVDS_GPIO = 8'hff;
   localparam logic [7:0] WMASK_CLK_SEL = 8'h7f;
   localparam logic [7:0] WMASK_TRIM_SPI = 8'hff;
   localparam logic [7:0] WMASK_CLK_OE = 8'h03;
   // Field positions in lvds_and_gpio_select
   localparam int POS_LVDS_TX_EN = 7;
   // Field positions in clock_output_select
   localparam int POS_PIN6_CLOCK_OUT_SELECT = 6;
   localparam int POS_PIN5_CLOCK_OUT_SELECT = 5;
   localparam int POS_EXTCLK_SEL = 4;
   localparam int POS_LVDS_CUR_HI = 3;
   localparam int POS_LVDS_CUR_LO = 2;
   localparam int POS_LVDS_BIAS_HI = 1;
   // Field positions in trim_and_spi_pin_select
   localparam int POS_OSC_TRIM_HI = 7;
   localparam int POS_OSC_TRIM_LO = 3;
   localparam int POS_PIN3_SERIAL_SELECT = 2;
   localparam int POS_SYNC_SRC_SEL = 1;
   localparam int POS_PIN1_SERIAL_SELECT = 0;
   // Field positions in clock_output_enable
   localparam int POS_PIN6_CLOCK_OUT_DRIVE_ENABLE = 1;
   localparam int POS_PIN5_CLOCK_OUT_DRIVE_ENABLE = 0;
   // Whole state of the block
   typedef struct packed {
      logic [7:0] lvds_gpio;
      logic [7:0] clk_sel;
      logic [7:0] trim_spi;
      logic [7:0] clk_oe;
      logic [6:0] pin_meta;
      logic [6:0] pin_sync;
      logic ack;
      logic [7:0] rdat;
      logic [6:0] io_out;
      logic [6:0] io_oe;
      logic [6:0] gpio_in;
      logic sd2_in;
      logic start_sync;
      logic extclk;
   } iopfs_state_t;
endpackage
`default_nettype wire

// File: iopfs_pins.sv
// Behavioural model of the package pins seen from outside the device
`timescale 1ns/1ps
`default_nettype none
module iopfs_pins (
   input wire logic i_clk,
   input wire logic [6:0] i_dev_out,
   input wire logic [6:0] i_dev_oe,
   input wire logic [6:0] i_ext_val,
   input wire logic [6:0] i_ext_en,
   output logic [6:0] o_level
);
   logic [6:0] noise_q = 7'h2a;
   // Floating pins have no pull, so show a level that changes every cycle
   always_ff @(posedge i_clk) begin
      noise_q <= ~noise_q;
   end
   // Device drive wins, else the outside driver
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         o_level[i] = i_dev_oe[i] ? i_dev_out[i] : (i_ext_en[i] ? i_ext_val[i] : noise_q[i]);
      end
   end
endmodule // iopfs_pins
`default_nettype wire

// File: iopfs_top_test.sv
// Self-checking bench for the I/O pin function select block
`timescale 1ns/1ps
`default_nettype none
module iopfs_top_test;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [9:0] adr = '0;
   logic [31:0] wdat = '0, rdat, q;
   logic [3:0] sel = '0;
   logic [26:0] src = 27'h5a3c96d;
   logic [6:0] pout, poe, lvl, gin, ext = 7'h4a, l;
   logic sd2i, ssync, eclk, txen;
   logic [1:0] cur, bias;
   logic [4:0] trim;
   logic [7:0] lg = 8'h66, cs = 8'h00, ts = 8'h05, co = 8'h00;
   logic [13:0] e;
   logic [7:0] tl[5] = '{8'h00, 8'h00, 8'h7f, 8'h80, 8'he0};
   logic [7:0] tc[5] = '{8'h00, 8'h70, 8'h0e, 8'h13, 8'h6d};
   logic [7:0] tt[5] = '{8'h00, 8'h07, 8'h02, 8'h85, 8'hfb};
   logic [7:0] to[5] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h03};
   int error_cnt = 0, n_checks = 0;
   always #5 clk = ~clk;
   iopfs_top dut (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_DAT(wdat), .I_WB_SEL(sel), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .I_IO_IN(lvl), .O_IO_OUT(pout), .O_IO_OE(poe),
      .I_GPIO_OUT(src[6:0]), .I_GPIO_OE(src[13:7]), .O_GPIO_IN(gin),
      .I_ALT_OUT(src[16:14]), .I_ALT_OE(src[19:17]), .I_TRX_CLKOUT_1(src[24]),
      .I_TRX_CLKOUT_2(src[25]), .I_CMU_CLKOUT(src[26]), .I_TRX_SYNC_OUT(src[22]),
      .I_SERIAL_DATA_LINE_TWO_OUT(src[20]), .I_SERIAL_DATA_LINE_TWO_OE(src[21]),
      .O_SERIAL_DATA_LINE_TWO_IN(sd2i), .I_SECOND_SLAVE_SELECT_OUTPUT(src[23]),
      .O_TRX_START_SYNC_IN(ssync), .O_EXTCLK(eclk), .O_LVDS_TX_EN(txen),
      .O_LVDS_DRIVE_CURRENT(cur), .O_LVDS_BIAS_TRIM(bias), .O_OSC_TRIM(trim));
   iopfs_pins pins (.i_clk(clk), .i_dev_out(pout), .i_dev_oe(poe), .i_ext_val(ext),
      .i_ext_en(7'h7f), .o_level(lvl));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      n_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, x, g);
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] s);
      int n;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      sel <= s;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         error_cnt++;
         $display("unexpected ack: expected 1, seen %b", ack);
         results();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] x);
      wb(1'b0, idx, 8'h00, 4'hf);
      chk("read data", {24'h0, x}, q);
   endtask
   // Pin multiplexing worked out from the register fields
   function automatic logic [13:0] pexp(input logic [26:0] s);
      logic [6:0] o, oe;
      o = {cs[6] ? s[26] : s[25], cs[5] ? s[26] : s[24], s[16],
           ts[2] ? s[20] : s[22], s[15], ts[0] ? s[23] : s[22], s[14]};
      oe = {co[1], co[0], s[19], ts[2] ? s[21] : 1'b1, s[18], 1'b1, s[17]};
      for (int i = 0; i < 7; i++) begin
         if (lg[i]) begin
            o[i] = s[i];
            oe[i] = s[7 + i];
         end
      end
      if (lg[7]) begin
         oe[6:5] = 2'b00;
      end
      return {oe, o};
   endfunction
   task automatic chk_all();
      e = pexp(src);
      l = (e[13:7] & e[6:0]) | (~e[13:7] & ext);
      repeat (6) @(posedge clk);
      chk("pin out", {25'h0, e[6:0]}, {25'h0, pout});
      chk("pin oe", {25'h0, e[13:7]}, {25'h0, poe});
      chk("gpio in", {25'h0, l}, {25'h0, gin});
      chk("ext clock", {31'h0, cs[4] ? l[5] : l[6]}, {31'h0, eclk});
      chk("start sync", {31'h0, ts[1] ? l[3] : l[1]}, {31'h0, ssync});
      chk("data two in", {31'h0, l[3]}, {31'h0, sd2i});
      chk("lvds enable", {31'h0, lg[7]}, {31'h0, txen});
      chk("lvds codes", {28'h0, cs[3:0]}, {28'h0, cur, bias});
      chk("osc trim", {27'h0, ts[7:3]}, {27'h0, trim});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h4d, 8'h66);
      rd(8'h4e, 8'h00);
      rd(8'h4f, 8'h05);
      rd(8'h51, 8'h00);
      chk_all();
      for (int i = 0; i < 5; i++) begin
         src <= ~src;
         ext <= ~ext;
         wb(1'b1, 8'h4d, tl[i], 4'h1);
         wb(1'b1, 8'h4e, tc[i], 4'h1);
         wb(1'b1, 8'h4f, tt[i], 4'h1);
         wb(1'b1, 8'h51, to[i], 4'h1);
         lg = tl[i];
         cs = tc[i];
         ts = tt[i];
         co = to[i];
         chk_all();
      end
      rd(8'h4f, ts);
      wb(1'b1, 8'h4e, 8'hff, 4'h1);
      rd(8'h4e, 8'h7f);
      wb(1'b1, 8'h51, 8'hff, 4'h1);
      rd(8'h51, 8'h03);
      wb(1'b1, 8'h4f, 8'h00, 4'he);
      rd(8'h4f, ts);
      wb(1'b1, 8'h50, 8'hff, 4'h1);
      rd(8'h50, 8'h00);
      results();
   end
endmodule // iopfs_top_test
`default_nettype wire
